// *** include/dwd_crc_if.sv ***
/*
 * carrier between the decoder and its frame checker.
 * assumes one clock; the checker is purely combinational.
 */
`timescale 1ns/1ps
`default_nettype none
interface dwd_crc_if;
  logic [31:0] frame;
  logic        crc_ok;
  modport dec (output frame, input crc_ok);
  modport chk (input frame, output crc_ok);
endinterface : dwd_crc_if
`default_nettype wire

// *** include/dwd_pkg.sv ***
/*
 * shared constants for the bus command decoder: frame layout, command codes,
 * byte addresses and register bits.
 * assumes a single clock domain; frames arrive already bit-decoded.
 */
`default_nettype none
package dwd_pkg;
  localparam int          FRAME_W        = 32;
  localparam int          ADDR_HI        = 31;
  localparam int          ADDR_LO        = 28;
  localparam int          CMD_HI         = 27;
  localparam int          CMD_LO         = 24;
  localparam int          DATA_HI        = 23;
  localparam int          DATA_LO        = 8;
  localparam int          CRC_HI         = 7;
  localparam int          CRC_LO         = 0;
  localparam logic [3:0]  CMD_REG_WRITE  = 4'h8;
  localparam logic [3:0]  CMD_ENTER_PER  = 4'hB;
  localparam logic [3:0]  GLOBAL_ADDR    = 4'h0;
  localparam logic [7:0]  BA_NODE_ADDR   = 8'h11;
  localparam logic [7:0]  BA_ABOVE_NODE  = 8'h12;
  localparam logic [7:0]  BA_CHIP_TIME   = 8'h13;
  localparam logic [7:0]  BA_MODE_CTRL   = 8'h14;
  localparam logic [7:0]  NODE_ADDR_RST  = 8'h00;
  localparam logic [7:0]  ABOVE_RST      = 8'h00;
  localparam logic [7:0]  CHIP_TIME_RST  = 8'h00;
  localparam logic [7:0]  MODE_CTRL_RST  = 8'h00;
  localparam int          MODE_PER_BIT   = 0;
  localparam int          MODE_DIAG_BIT  = 1;
  localparam logic [7:0]  MODE_WR_MASK   = 8'h03;
  localparam logic [7:0]  CHIP_WR_MASK   = 8'h07;
  localparam logic [15:0] ENTER_RESP_ONE = 16'h0080;
  localparam int          CHIP_FIELD_LO  = 8;
  localparam int          CHIP_FIELD_HI  = 2;
  localparam int          TA_LO          = 16;
  localparam int          VAL_HI         = 15;
  localparam int          NODE_NIB_HI    = 3;
  localparam logic [7:0]  BA_STEP        = 8'h01;
  typedef enum logic [1:0] {
    DWD_IDLE  = 2'b00,
    DWD_CHECK = 2'b01,
    DWD_EXEC  = 2'b11
  } dwd_state_t;
endpackage : dwd_pkg
`default_nettype wire

// *** rtl/dwd_crc_check.sv ***
/*
 * frame check: compares the trailing byte against the crc computed elsewhere.
 * assumes the crc generator outside supplies expected_crc for the held frame.
 */
`timescale 1ns/1ps
`default_nettype none
module dwd_crc_check
  import dwd_pkg::*;
(
  dwd_crc_if.chk      port_c,
  input  wire logic [7:0] expected_crc
);
  assign port_c.crc_ok = (port_c.frame[CRC_HI:CRC_LO] == expected_crc);
endmodule : dwd_crc_check
`default_nettype wire

// *** rtl/dwd_decoder.sv ***
/*
 * command decoder of a bus satellite: register write, global address
 * assignment and entry into periodic collection; builds the reply frame.
 * assumes frames arrive whole on cmd_valid and crc is computed outside.
 */
`timescale 1ns/1ps
`default_nettype none
module dwd_decoder
  import dwd_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        cmd_valid,
  input  wire logic [31:0] cmd_frame,
  input  wire logic [7:0]  expected_crc,
  output logic             resp_valid,
  output logic [23:0]      resp_frame,
  output logic             periodic_collection_mode,
  output logic             diag_mode_active,
  output logic [3:0]       frame_address_field,
  output logic             frame_dropped
);
  // ----------------------------------------------------------------------
  // frame capture and check
  // ----------------------------------------------------------------------
  dwd_crc_if  crc_c ();
  dwd_state_t state;
  logic [31:0] held;
  logic [7:0]  bus_node_address;
  logic [7:0]  above_node;
  logic [7:0]  chip_time_setting;
  logic [7:0]  diag_mode_config;
  logic [3:0]  f_addr;
  logic [3:0]  f_cmd;
  logic [7:0]  target_byte_address;
  logic [7:0]  f_val;
  logic        own_hit;
  logic        glob_hit;
  logic        do_write;
  logic        glob_write;
  logic        do_enter;
  logic        enter_reply;
  logic        writable;
  logic [7:0]  next_target;
  logic [7:0]  above_val;
  logic [3:0]  node_nib;
  logic [3:0]  reply_addr;

  assign crc_c.frame = held;

  dwd_crc_check u_chk (
    .port_c       (crc_c),
    .expected_crc (expected_crc)
  );

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      held <= '0;
    end else if (state == DWD_IDLE && cmd_valid) begin
      held <= cmd_frame;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= DWD_IDLE;
    end else begin
      unique case (state)
        DWD_IDLE:  if (cmd_valid) state <= DWD_CHECK;
        DWD_CHECK: state <= crc_c.crc_ok ? DWD_EXEC : DWD_IDLE;
        DWD_EXEC:  state <= DWD_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      frame_dropped <= 1'b0;
    end else begin
      frame_dropped <= (state == DWD_CHECK) && !crc_c.crc_ok;
    end
  end

  // ----------------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------------
  assign f_addr              = held[ADDR_HI:ADDR_LO];
  assign f_cmd               = held[CMD_HI:CMD_LO];
  assign target_byte_address = held[DATA_HI:TA_LO];
  assign f_val               = held[VAL_HI:DATA_LO];
  assign node_nib            = bus_node_address[NODE_NIB_HI:0];
  assign own_hit  = (f_addr == node_nib) && (f_addr != GLOBAL_ADDR);
  assign glob_hit = (f_addr == GLOBAL_ADDR);
  assign glob_write = (state == DWD_EXEC) && (f_cmd == CMD_REG_WRITE) && glob_hit
                      && (target_byte_address == BA_NODE_ADDR)
                      && (node_nib == GLOBAL_ADDR);
  assign do_write = ((state == DWD_EXEC) && (f_cmd == CMD_REG_WRITE) && own_hit)
                    || glob_write;
  assign do_enter = (state == DWD_EXEC) && (f_cmd == CMD_ENTER_PER)
                    && (own_hit || glob_hit);
  assign enter_reply = do_enter && own_hit;

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_node_address <= NODE_ADDR_RST;
    end else if (do_write && target_byte_address == BA_NODE_ADDR) begin
      bus_node_address <= f_val;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      chip_time_setting <= CHIP_TIME_RST;
    end else if (do_write && !glob_write && target_byte_address == BA_CHIP_TIME) begin
      chip_time_setting <= f_val & CHIP_WR_MASK;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      diag_mode_config <= MODE_CTRL_RST;
    end else if (do_enter) begin
      diag_mode_config[MODE_PER_BIT] <= 1'b1;
    end else if (do_write && !glob_write && target_byte_address == BA_MODE_CTRL) begin
      diag_mode_config <= f_val & MODE_WR_MASK;
    end
  end

  assign above_node = ABOVE_RST;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      periodic_collection_mode <= 1'b0;
    end else begin
      periodic_collection_mode <= diag_mode_config[MODE_PER_BIT];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      diag_mode_active <= 1'b0;
    end else begin
      diag_mode_active <= diag_mode_config[MODE_PER_BIT]
                          && diag_mode_config[MODE_DIAG_BIT];
    end
  end

  // ----------------------------------------------------------------------
  // reply build
  // ----------------------------------------------------------------------
  function automatic logic [7:0] reg_read(input logic [7:0] ba, input logic [7:0] node);
    unique case (ba)
      BA_NODE_ADDR:  reg_read = node;
      BA_ABOVE_NODE: reg_read = above_node;
      BA_CHIP_TIME:  reg_read = chip_time_setting;
      BA_MODE_CTRL:  reg_read = diag_mode_config;
      default:       reg_read = '0;
    endcase
  endfunction : reg_read

  assign writable = (target_byte_address == BA_NODE_ADDR) || (target_byte_address == BA_CHIP_TIME)
                    || (target_byte_address == BA_MODE_CTRL);
  assign next_target = (target_byte_address == BA_NODE_ADDR) ? f_val
                       : (target_byte_address == BA_CHIP_TIME) ? (f_val & CHIP_WR_MASK)
                       : (f_val & MODE_WR_MASK);
  // process form so register contents read inside the function are tracked
  always_comb begin
    above_val = reg_read(8'(target_byte_address + BA_STEP),
                         (target_byte_address == BA_MODE_CTRL) ? bus_node_address : next_target);
  end

  assign reply_addr = glob_write ? f_val[NODE_NIB_HI:0] : node_nib;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      resp_valid <= 1'b0;
    end else begin
      resp_valid <= do_write || enter_reply;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      frame_address_field <= '0;
    end else if (do_write) begin
      frame_address_field <= reply_addr;
    end else if (enter_reply) begin
      frame_address_field <= node_nib;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      resp_frame <= '0;
    end else if (do_write && writable) begin
      resp_frame <= {reply_addr, CMD_REG_WRITE, above_val, next_target};
    end else if (do_write) begin
      resp_frame <= {reply_addr, CMD_REG_WRITE, 16'h0000};
    end else if (enter_reply) begin
      resp_frame <= {node_nib, CMD_ENTER_PER,
                     ENTER_RESP_ONE | (16'(chip_time_setting[CHIP_FIELD_HI:0]) << CHIP_FIELD_LO)};
    end
  end
endmodule : dwd_decoder
`default_nettype wire

// *** verification/dwd_checker.sv ***
/* port assertions of the decoder.
   assumes it is bound to dwd_decoder. */
`timescale 1ns/1ps
`default_nettype none
module dwd_checker
  import dwd_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        cmd_valid,
  input wire logic [31:0] cmd_frame,
  input wire logic        resp_valid,
  input wire logic [23:0] resp_frame,
  input wire logic        periodic_collection_mode,
  input wire logic        diag_mode_active,
  input wire logic [3:0]  frame_address_field,
  input wire logic        frame_dropped
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_resp_latency: assert property (resp_valid |-> $past(cmd_valid, 3))
    else $error("reply without command");
  a_resp_pulse: assert property (resp_valid |=> !resp_valid)
    else $error("reply too long");
  a_drop_slot: assert property (frame_dropped |-> $past(cmd_valid, 2) ##1 !resp_valid)
    else $error("dropped frame misplaced or answered");
  a_cmd_echo: assert property (resp_valid |-> resp_frame[19:16] == $past(cmd_frame[27:24], 3))
    else $error("reply command mismatch");
  a_own_addr: assert property (resp_valid && $past(cmd_frame[31:28], 3) != GLOBAL_ADDR
    |-> resp_frame[23:20] == $past(cmd_frame[31:28], 3))
    else $error("reply to foreign address");
  a_global_mute: assert property (resp_valid |-> !($past(cmd_frame[31:28], 3) == GLOBAL_ADDR
    && $past(cmd_frame[27:24], 3) == CMD_ENTER_PER)) else $error("global entry answered");
  a_enter_data: assert property (resp_valid && resp_frame[19:16] == CMD_ENTER_PER
    |-> resp_frame[15:11] == 5'h00 && resp_frame[7:0] == 8'h80) else $error("entry reply data");
  a_field_copy: assert property (resp_valid |-> frame_address_field == resp_frame[23:20])
    else $error("address field mismatch");
  a_diag_needs_per: assert property (diag_mode_active |-> periodic_collection_mode)
    else $error("diag without periodic");
  c_reply: cover property (resp_valid);
  c_drop: cover property (frame_dropped);
  c_diag: cover property (diag_mode_active);
  c_enter_reply: cover property (resp_valid && resp_frame[19:16] == CMD_ENTER_PER);
endmodule : dwd_checker
bind dwd_decoder dwd_checker i_dwd_checker (.clk, .rst_n, .cmd_valid, .cmd_frame, .resp_valid,
  .resp_frame, .periodic_collection_mode, .diag_mode_active, .frame_address_field, .frame_dropped);
`default_nettype wire

// *** verification/dwd_master_model.sv ***
/* bus master model: sends one whole frame per go pulse.
   assumes go is a one-cycle pulse on clk. */
`timescale 1ns/1ps
`default_nettype none
module dwd_master_model
  import dwd_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        go,
  input  wire logic [23:0] frame_in,
  input  wire logic        bad,
  output logic             cmd_valid,
  output logic [31:0]      cmd_frame,
  output logic [7:0]       expected_crc
);
  // frame is 4+4+16 then crc byte; frame_in already holds the coded fields
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_valid    <= 1'b0;
      cmd_frame    <= 32'h0;
      expected_crc <= 8'h0;
    end else begin
      cmd_valid    <= go;
      cmd_frame    <= go ? {frame_in, 8'hA5} : ~cmd_frame;
      expected_crc <= go ? (bad ? 8'h5A : 8'hA5) : (cmd_valid ? expected_crc : ~expected_crc);
    end
  end
endmodule : dwd_master_model
`default_nettype wire

// *** verification/tb_dwd_decoder.sv ***
/* self-checking bench of the decoder.
   assumes the master model and bound checker. */
`timescale 1ns/1ps
`default_nettype none
module tb_dwd_decoder
  import dwd_pkg::*;
;
  logic clk, rst_n, go, bad, cmd_valid, resp_valid, per, diag, drop, seen, dropped;
  logic [23:0] frame_in, resp_frame;
  logic [31:0] cmd_frame;
  logic [7:0]  expected_crc;
  logic [3:0]  fa;
  int          n_fail, checks_done;
  dwd_master_model i_dwd_master_model (.clk, .rst_n, .go, .frame_in, .bad, .cmd_valid, .cmd_frame, .expected_crc);
  dwd_decoder i_dwd_decoder (.clk, .rst_n, .cmd_valid, .cmd_frame, .expected_crc, .resp_valid, .resp_frame,
    .periodic_collection_mode(per), .diag_mode_active(diag), .frame_address_field(fa), .frame_dropped(drop));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %0h exp %0h", $time, got, exp);
    end
  endtask : check
  task automatic send(input logic [23:0] f, input logic b);
    @(posedge clk);
    frame_in <= f;
    bad      <= b;
    go       <= 1'b1;
    @(posedge clk);
    go      <= 1'b0;
    seen    = 1'b0;
    dropped = 1'b0;
    repeat (7) begin
      @(posedge clk);
      #1;
      seen    = seen | resp_valid;
      dropped = dropped | drop;
    end
  endtask : send
  task automatic t_assign;
    send({GLOBAL_ADDR, CMD_REG_WRITE, BA_NODE_ADDR, 8'h05}, 1'b0);
    check({seen, resp_frame, fa}, {1'b1, 24'h580005, 4'h5});
    send({GLOBAL_ADDR, CMD_REG_WRITE, BA_NODE_ADDR, 8'h07}, 1'b0);
    check(seen, 1'b0);
    send({GLOBAL_ADDR, CMD_REG_WRITE, BA_CHIP_TIME, 8'h01}, 1'b0);
    check(seen, 1'b0);
  endtask : t_assign
  task automatic t_write;
    send({4'h5, CMD_REG_WRITE, BA_CHIP_TIME, 8'hFF}, 1'b1);
    check({seen, dropped}, 2'b01);
    send({4'h5, CMD_REG_WRITE, BA_CHIP_TIME, 8'hFF}, 1'b0);
    check({seen, resp_frame}, {1'b1, 24'h580007});
    send({4'h3, CMD_REG_WRITE, BA_CHIP_TIME, 8'h00}, 1'b0);
    check(seen, 1'b0);
    send({4'h5, CMD_REG_WRITE, BA_ABOVE_NODE, 8'h55}, 1'b0);
    check({seen, resp_frame}, {1'b1, 24'h580000});
  endtask : t_write
  task automatic t_enter;
    send({4'h3, CMD_ENTER_PER, 16'h0}, 1'b0);
    check({seen, per}, 2'b00);
    send({4'h5, CMD_ENTER_PER, 16'h0}, 1'b0);
    check({seen, per, resp_frame}, {2'b11, 24'h5B0780});
    send({4'h5, CMD_REG_WRITE, BA_MODE_CTRL, 8'h03}, 1'b0);
    check({per, diag, resp_frame[7:0]}, {2'b11, 8'h03});
    send({4'h5, CMD_REG_WRITE, BA_MODE_CTRL, 8'h00}, 1'b0);
    check({per, diag}, 2'b00);
    send({GLOBAL_ADDR, CMD_ENTER_PER, 16'h0}, 1'b0);
    check({seen, per}, 2'b01);
  endtask : t_enter
  task automatic t_reset;
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    check({per, diag, fa, resp_frame}, 30'h0);
    send({GLOBAL_ADDR, CMD_REG_WRITE, BA_NODE_ADDR, 8'h03}, 1'b0);
    check({seen, resp_frame, fa}, {1'b1, 24'h380003, 4'h3});
    send({4'h3, CMD_REG_WRITE, BA_NODE_ADDR, 8'h09}, 1'b0);
    check({seen, resp_frame, fa}, {1'b1, 24'h380009, 4'h3});
    send({4'h9, CMD_ENTER_PER, 16'h0}, 1'b0);
    check({seen, per, resp_frame}, {2'b11, 24'h9B0080});
  endtask : t_reset
  task automatic end_sim;
    $display("checks %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_sim
  initial begin
    rst_n = 1'b0;
    go = 1'b0;
    bad = 1'b0;
    frame_in = 24'h0;
    n_fail = 0;
    checks_done = 0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    check({per, diag, fa}, 6'h00);
    t_assign;
    t_write;
    t_enter;
    t_reset;
    end_sim;
  end
  initial begin
    #20000;
    n_fail++;
    end_sim;
  end
endmodule : tb_dwd_decoder
`default_nettype wire
